// [bench/ipfsm_le_model.sv]
// Behavioural model of the exchange-side port control that faces the access-side machine.
`timescale 1ns/1ps
module ipfsm_le_model (
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 an_fe_valid_i,
	input  wire ipfsm_pkg::ipfsm_fe_t an_fe_code_i,
	output logic                      le_fe_valid_o,
	output ipfsm_pkg::ipfsm_fe_t      le_fe_code_o
);
	// Cycles before an unblock is acknowledged; zero leaves the unblock waiting.
	int   ack_dly = 0;
	int   cnt     = 0;
	logic auto_out = 1'b0;

	initial begin
		le_fe_valid_o = 1'b0;
		le_fe_code_o  = ipfsm_pkg::FE_NONE;
	end

	task automatic fire(input ipfsm_pkg::ipfsm_fe_t c);
		le_fe_valid_o <= 1'b1;
		le_fe_code_o  <= c;
	endtask

	// A released code line shows the inverse of its last value, not a stale copy.
	task automatic idle();
		le_fe_valid_o <= 1'b0;
		le_fe_code_o  <= ipfsm_pkg::ipfsm_fe_t'(~le_fe_code_o);
	endtask

	// Management agrees to the access side's unblock after a delay and acknowledges it.
	always @(negedge core_clk_i) begin
		if (!rst_n_i) begin
			cnt <= 0;
		end else if (an_fe_valid_i && an_fe_code_i == ipfsm_pkg::FE_UNBLOCK && ack_dly > 0) begin
			cnt <= ack_dly;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
		if (cnt == 1) begin
			fire(ipfsm_pkg::FE_UNBLOCK);
			auto_out <= 1'b1;
		end else if (auto_out) begin
			idle();
			auto_out <= 1'b0;
		end
	end
endmodule

// [bench/tb.sv]
// Self-checking testbench of the access-side port state machine.
`timescale 1ns/1ps
module tb;
	typedef struct {
		int         src;
		logic [6:0] code;
		logic [2:0] st;
		logic       mv;
		logic [3:0] mc;
		logic       lv;
		logic [6:0] lc;
		logic       rai;
	} ipfsm_row_t;

	logic                   core_clk_i = 1'b0;
	logic                   rst_n_i = 1'b0;
	logic                   le_fe_valid_i;
	ipfsm_pkg::ipfsm_fe_t   le_fe_code_i;
	logic                   mgmt_valid_i = 1'b0;
	ipfsm_pkg::ipfsm_prim_t mgmt_code_i = ipfsm_pkg::PRIM_NONE;
	logic                   ds_valid = 1'b0;
	ipfsm_pkg::ipfsm_ds_t   ds_code = ipfsm_pkg::DS_NORMAL;
	logic                   le_fe_valid_o;
	ipfsm_pkg::ipfsm_fe_t   le_fe_code_o;
	logic                   mgmt_valid_o;
	ipfsm_pkg::ipfsm_prim_t mgmt_code_o;
	logic                   ds_report_valid_o;
	ipfsm_pkg::ipfsm_ds_t   ds_report_code_o;
	ipfsm_pkg::ipfsm_ds_t   ds_condition_o;
	logic                   ds_multi_o;
	logic                   dch_blocked_o;
	logic                   user_rai_o;
	ipfsm_pkg::ipfsm_state_t state_o;
	int                     error_cnt = 0;
	int                     samples_checked = 0;
	ipfsm_row_t             rows [18];

	always #4 core_clk_i = ~core_clk_i;

	ipfsm_port dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .le_fe_valid_i(le_fe_valid_i),
		.le_fe_code_i(le_fe_code_i), .mgmt_valid_i(mgmt_valid_i), .mgmt_code_i(mgmt_code_i),
		.digital_section_valid_i(ds_valid), .digital_section_code_i(ds_code),
		.le_fe_valid_o(le_fe_valid_o), .le_fe_code_o(le_fe_code_o), .mgmt_valid_o(mgmt_valid_o),
		.mgmt_code_o(mgmt_code_o), .ds_report_valid_o(ds_report_valid_o),
		.ds_report_code_o(ds_report_code_o), .ds_condition_o(ds_condition_o),
		.ds_multi_o(ds_multi_o), .dch_blocked_o(dch_blocked_o), .user_rai_o(user_rai_o),
		.state_o(state_o));

	ipfsm_le_model le (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .an_fe_valid_i(le_fe_valid_o),
		.an_fe_code_i(le_fe_code_o), .le_fe_valid_o(le_fe_valid_i), .le_fe_code_o(le_fe_code_i));

	task automatic chk_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_val(input logic [6:0] got, input logic [6:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// Source 0 is management, 1 the exchange, 2 the digital section (one stage later).
	task automatic ev(input ipfsm_row_t r);
		@(negedge core_clk_i);
		if (r.src == 0) begin
			mgmt_valid_i <= 1'b1;
			mgmt_code_i  <= ipfsm_pkg::ipfsm_prim_t'(r.code[3:0]);
		end else if (r.src == 1) begin
			le.fire(ipfsm_pkg::ipfsm_fe_t'(r.code));
		end else begin
			ds_valid <= 1'b1;
			ds_code  <= ipfsm_pkg::ipfsm_ds_t'(r.code[3:0]);
		end
		@(negedge core_clk_i);
		mgmt_valid_i <= 1'b0;
		ds_valid     <= 1'b0;
		if (r.src == 1) le.idle();
		if (r.src == 2) @(negedge core_clk_i);
		chk_val({4'h0, state_o}, {4'h0, r.st}, "state");
		chk_bit(mgmt_valid_o, r.mv, "mgmt valid");
		if (r.mv) chk_val({3'h0, mgmt_code_o}, {3'h0, r.mc}, "mgmt code");
		chk_bit(le_fe_valid_o, r.lv, "element valid");
		if (r.lv) chk_val(le_fe_code_o, r.lc, "element code");
		chk_bit(user_rai_o, r.rai, "user alarm");
		chk_bit(ds_report_valid_o, r.src == 2 && r.code != 7'h00, "ds report");
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge core_clk_i);
		error_cnt++;
		results();
	end

	initial begin
		rows = '{
			'{1, 7'h11, 3'h7, 1, 4'h1, 0, 7'h00, 0},
			'{1, 7'h13, 3'h0, 1, 4'h3, 0, 7'h00, 0},
			'{0, 7'h01, 3'h0, 1, 4'h3, 0, 7'h00, 0},
			'{0, 7'h05, 3'h0, 0, 4'h0, 1, 7'h19, 0},
			'{0, 7'h06, 3'h0, 0, 4'h0, 1, 7'h1a, 0},
			'{2, 7'h01, 3'h1, 0, 4'h0, 0, 7'h00, 1},
			'{0, 7'h01, 3'h3, 0, 4'h0, 1, 7'h11, 1},
			'{0, 7'h07, 3'h6, 1, 4'h8, 0, 7'h00, 0},
			'{0, 7'h09, 3'h1, 1, 4'ha, 0, 7'h00, 1},
			'{1, 7'h11, 3'h5, 1, 4'h1, 0, 7'h00, 1},
			'{1, 7'h13, 3'h1, 1, 4'h3, 0, 7'h00, 1},
			'{0, 7'h01, 3'h3, 0, 4'h0, 1, 7'h11, 1},
			'{1, 7'h11, 3'h2, 1, 4'h2, 0, 7'h00, 0},
			'{0, 7'h01, 3'h2, 1, 4'h2, 1, 7'h11, 0},
			'{0, 7'h04, 3'h2, 0, 4'h0, 1, 7'h15, 0},
			'{0, 7'h0b, 3'h2, 0, 4'h0, 1, 7'h16, 0},
			'{0, 7'h03, 3'h1, 0, 4'h0, 1, 7'h13, 1},
			'{2, 7'h00, 3'h1, 1, 4'he, 0, 7'h00, 1}
		};
		repeat (16) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk_val({4'h0, state_o}, 7'h00, "reset state");
		chk_bit(user_rai_o, 1'b0, "reset alarm");
		chk_bit(le_fe_valid_o | mgmt_valid_o, 1'b0, "reset outputs");
		$display("test reset done");
		foreach (rows[i]) ev(rows[i]);
		$display("test table done");
		// The exchange acknowledges late; the port must wait in local unblock meanwhile.
		le.ack_dly = 5;
		ev('{0, 7'h01, 3'h3, 0, 4'h0, 1, 7'h11, 1});
		for (int i = 0; i < 20 && state_o !== ipfsm_pkg::ST_OPER; i++) @(negedge core_clk_i);
		chk_val({4'h0, state_o}, 7'h02, "late unblock");
		le.ack_dly = 0;
		$display("test late unblock done");
		ev('{1, 7'h17, 3'h2, 1, 4'hc, 0, 7'h00, 0});
		chk_bit(dch_blocked_o, 1'b1, "dch blocked");
		ev('{1, 7'h18, 3'h2, 1, 4'hd, 0, 7'h00, 0});
		chk_bit(dch_blocked_o, 1'b0, "dch unblocked");
		ev('{1, 7'h17, 3'h2, 1, 4'hc, 0, 7'h00, 0});
		ev('{2, 7'h01, 3'h1, 0, 4'h0, 1, 7'h13, 1});
		chk_bit(dch_blocked_o, 1'b0, "dch released");
		chk_val({3'h0, ds_report_code_o}, 7'h01, "report code");
		ev('{2, 7'h06, 3'h1, 0, 4'h0, 0, 7'h00, 1});
		chk_bit(ds_multi_o, 1'b1, "combined failure");
		chk_val({3'h0, ds_condition_o}, 7'h06, "condition");
		ev('{2, 7'h02, 3'h1, 0, 4'h0, 0, 7'h00, 1});
		chk_bit(ds_multi_o, 1'b0, "single failure");
		chk_val({3'h0, ds_condition_o}, 7'h02, "new condition");
		ev('{2, 7'h07, 3'h1, 0, 4'h0, 0, 7'h00, 1});
		ev('{2, 7'h09, 3'h1, 0, 4'h0, 0, 7'h00, 1});
		chk_val({3'h0, ds_condition_o}, 7'h09, "last condition");
		$display("test digital section done");
		results();
	end
endmodule

// [hdl/ipfsm_ds_if.sv]
// Link between the port state machine and its digital section event tracker.
`timescale 1ns/1ps
interface ipfsm_ds_if;
	logic                clk;
	logic                rst_n;
	logic                in_valid;
	ipfsm_pkg::ipfsm_ds_t in_code;
	logic                evt_valid;
	ipfsm_pkg::ipfsm_ds_t evt_code;
	logic                evt_multi;
	ipfsm_pkg::ipfsm_ds_t active_code;

	modport fsm (
		output clk,
		output rst_n,
		output in_valid,
		output in_code,
		input  evt_valid,
		input  evt_code,
		input  evt_multi,
		input  active_code
	);

	modport track (
		input  clk,
		input  rst_n,
		input  in_valid,
		input  in_code,
		output evt_valid,
		output evt_code,
		output evt_multi,
		output active_code
	);
endinterface

// [hdl/ipfsm_ds_track.sv]
// Registers digital section events and keeps only the newest failure condition.
`timescale 1ns/1ps
module ipfsm_ds_track (
	ipfsm_ds_if.track ds
);
	logic                 valid_reg;
	logic                 valid_next;
	ipfsm_pkg::ipfsm_ds_t code_reg;
	ipfsm_pkg::ipfsm_ds_t code_next;
	logic                 multi_reg;
	logic                 multi_next;
	ipfsm_pkg::ipfsm_ds_t active_reg;
	ipfsm_pkg::ipfsm_ds_t active_next;

	always_comb begin
		valid_next  = ds.in_valid;
		code_next   = code_reg;
		multi_next  = multi_reg;
		active_next = active_reg;
		if (ds.in_valid) begin
			code_next   = ds.in_code;
			// Only these two events stand for several failures at once.
			multi_next  = (ds.in_code == ipfsm_pkg::DS_EV_H) ||
				(ds.in_code == ipfsm_pkg::DS_EV_K);
			// A new event overwrites the old condition, which counts as gone.
			active_next = ds.in_code;
		end
	end

	always_ff @(posedge ds.clk or negedge ds.rst_n) begin
		if (!ds.rst_n) begin
			valid_reg  <= 1'b0;
			code_reg   <= ipfsm_pkg::DS_NORMAL;
			multi_reg  <= 1'b0;
			active_reg <= ipfsm_pkg::DS_NORMAL;
		end else begin
			valid_reg  <= valid_next;
			code_reg   <= code_next;
			multi_reg  <= multi_next;
			active_reg <= active_next;
		end
	end

	assign ds.evt_valid   = valid_reg;
	assign ds.evt_code    = code_reg;
	assign ds.evt_multi   = multi_reg;
	assign ds.active_code = active_reg;

	a_newest_event_wins: assert property (
		@(posedge ds.clk) disable iff (!ds.rst_n)
		ds.in_valid |=> (ds.active_code == $past(ds.in_code)) && ds.evt_valid)
		else $error("newest digital section event not taken as the condition");

	a_multi_flag_only: assert property (
		@(posedge ds.clk) disable iff (!ds.rst_n)
		ds.evt_valid && ds.evt_multi |->
			(ds.evt_code == ipfsm_pkg::DS_EV_H) || (ds.evt_code == ipfsm_pkg::DS_EV_K))
		else $error("multiple failure flag on a single event type");
endmodule

// [hdl/ipfsm_pkg.sv]
// Shared types and constants of the primary-rate access-side port state machine.
package ipfsm_pkg;

	// Port states, Gray coded along blocked -> local unblock -> operational -> permanent line.
	typedef enum logic [2:0] {
		ST_BLOCKED1  = 3'h0,
		ST_BLOCKED2  = 3'h1,
		ST_LOCAL_UB  = 3'h3,
		ST_OPER      = 3'h2,
		ST_PERM_LINE = 3'h6,
		ST_REMOTE1   = 3'h7,
		ST_REMOTE2   = 3'h5
	} ipfsm_state_t;

	// Control function element codes as carried in octet 3 of the control protocol.
	typedef enum logic [6:0] {
		FE_NONE       = 7'h00,
		FE_UNBLOCK    = 7'h11,
		FE_BLOCK      = 7'h13,
		FE_BLOCK_REQ  = 7'h15,
		FE_GRADING    = 7'h16,
		FE_DCH_BLOCK  = 7'h17,
		FE_DCH_UNBLK  = 7'h18,
		FE_TE_OOS     = 7'h19,
		FE_NET_FAIL   = 7'h1a
	} ipfsm_fe_t;

	// Management primitives in both directions.
	typedef enum logic [3:0] {
		PRIM_NONE       = 4'h0,
		PRIM_UNBLK_REQ  = 4'h1,
		PRIM_UNBLK_IND  = 4'h2,
		PRIM_BLOCK_IND  = 4'h3,
		PRIM_BLOCK_REQ  = 4'h4,
		PRIM_USER_FAIL  = 4'h5,
		PRIM_NET_FAIL   = 4'h6,
		PRIM_PL_ACT_REQ = 4'h7,
		PRIM_PL_ACT_IND = 4'h8,
		PRIM_PL_DEA_REQ = 4'h9,
		PRIM_PL_DEA_IND = 4'ha,
		PRIM_GRADING    = 4'hb,
		PRIM_DCH_BLOCK  = 4'hc,
		PRIM_DCH_UNBLK  = 4'hd,
		PRIM_NORMAL_OP  = 4'he
	} ipfsm_prim_t;

	// Digital section events.
	typedef enum logic [3:0] {
		DS_NORMAL  = 4'h0,
		DS_LOS_LFA = 4'h1,
		DS_EV_C    = 4'h2,
		DS_EV_D    = 4'h3,
		DS_EV_E    = 4'h4,
		DS_EV_G    = 4'h5,
		DS_EV_H    = 4'h6,
		DS_EV_I    = 4'h7,
		DS_EV_K    = 4'h8,
		DS_EV_L    = 4'h9
	} ipfsm_ds_t;

	localparam ipfsm_state_t STATE_RESET = ST_BLOCKED1;
	localparam int           SYNC_STAGES = 2;

endpackage

// [hdl/ipfsm_port.sv]
// Access-side state machine for one primary-rate user port.
`timescale 1ns/1ps
// What this block does
// - A permanent-line activation request in local unblock enters permanent-line state and confirms.
// - A permanent-line deactivation request in permanent-line state goes to blocked 2 and indicates it.
// - D-channel blocking set by the exchange while operational is removed when operational is left.
// - Digital section failures are single events except the two combined-failure event types.
// - A newly detected digital section event clears any earlier failure and alone is acted on.
// - An unblock request from management yields an unblock indication when operational or in remote unblock 2, and enters operational.
// - The operational check is answered locally with no wait on the exchange.
// - A block indication from management sends block to the exchange and enters blocked 2, or blocked 1 from blocked 1 or remote unblock 1.
// - In remote unblock, a block element from the exchange returns to blocked and tells management.
// - User or network failure primitives send the matching out-of-service or network-failure element, in the blocked and remote unblock states only.
module ipfsm_port (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   le_fe_valid_i,
	input  wire ipfsm_pkg::ipfsm_fe_t   le_fe_code_i,
	input  wire logic                   mgmt_valid_i,
	input  wire ipfsm_pkg::ipfsm_prim_t mgmt_code_i,
	input  wire logic                   digital_section_valid_i,
	input  wire ipfsm_pkg::ipfsm_ds_t   digital_section_code_i,
	output logic                        le_fe_valid_o,
	output ipfsm_pkg::ipfsm_fe_t        le_fe_code_o,
	output logic                        mgmt_valid_o,
	output ipfsm_pkg::ipfsm_prim_t      mgmt_code_o,
	output logic                        ds_report_valid_o,
	output ipfsm_pkg::ipfsm_ds_t        ds_report_code_o,
	output ipfsm_pkg::ipfsm_ds_t        ds_condition_o,
	output logic                        ds_multi_o,
	output logic                        dch_blocked_o,
	output logic                        user_rai_o,
	output ipfsm_pkg::ipfsm_state_t     state_o
);
	logic [ipfsm_pkg::SYNC_STAGES-1:0] rst_sync_reg;
	logic                              rst_n;
	ipfsm_ds_if                        ds_if ();

	// Reset enters asynchronously and leaves only through the synchroniser, to avoid a split release.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_reg <= '0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[ipfsm_pkg::SYNC_STAGES-1];

	assign ds_if.clk      = core_clk_i;
	assign ds_if.rst_n    = rst_n;
	assign ds_if.in_valid = digital_section_valid_i;
	assign ds_if.in_code  = digital_section_code_i;

	ipfsm_ds_track u_ds_track (
		.ds (ds_if.track)
	);

	ipfsm_pkg::ipfsm_state_t state_reg;
	ipfsm_pkg::ipfsm_state_t state_next;
	logic                    fe_valid_reg;
	logic                    fe_valid_next;
	ipfsm_pkg::ipfsm_fe_t    fe_code_reg;
	ipfsm_pkg::ipfsm_fe_t    fe_code_next;
	logic                    prim_valid_reg;
	logic                    prim_valid_next;
	ipfsm_pkg::ipfsm_prim_t  prim_code_reg;
	ipfsm_pkg::ipfsm_prim_t  prim_code_next;
	logic                    rep_valid_reg;
	logic                    rep_valid_next;
	ipfsm_pkg::ipfsm_ds_t    rep_code_reg;
	ipfsm_pkg::ipfsm_ds_t    rep_code_next;
	logic                    dch_reg;
	logic                    dch_next;
	logic                    ds_go;
	logic                    mgmt_go;
	logic                    le_go;

	// One event per cycle: digital section first, then management, then the exchange.
	// Events of lower priority in the same cycle are dropped, so senders must space them.
	assign ds_go   = ds_if.evt_valid;
	assign mgmt_go = mgmt_valid_i && !ds_go;
	assign le_go   = le_fe_valid_i && !ds_go && !mgmt_valid_i;

	always_comb begin
		state_next      = state_reg;
		fe_valid_next   = 1'b0;
		fe_code_next    = fe_code_reg;
		prim_valid_next = 1'b0;
		prim_code_next  = prim_code_reg;
		rep_valid_next  = 1'b0;
		rep_code_next   = rep_code_reg;
		if (ds_go) begin
			rep_code_next = ds_if.evt_code;
			rep_valid_next = (ds_if.evt_code != ipfsm_pkg::DS_NORMAL);
			case (ds_if.evt_code)
			ipfsm_pkg::DS_NORMAL: begin
				prim_valid_next = (state_reg == ipfsm_pkg::ST_BLOCKED1) ||
					(state_reg == ipfsm_pkg::ST_BLOCKED2) ||
					(state_reg == ipfsm_pkg::ST_REMOTE1) ||
					(state_reg == ipfsm_pkg::ST_REMOTE2);
				prim_code_next = ipfsm_pkg::PRIM_NORMAL_OP;
				if (state_reg == ipfsm_pkg::ST_BLOCKED1)
					state_next = ipfsm_pkg::ST_BLOCKED2;
				if (state_reg == ipfsm_pkg::ST_REMOTE1)
					state_next = ipfsm_pkg::ST_REMOTE2;
			end
			ipfsm_pkg::DS_EV_I: begin
			end
			ipfsm_pkg::DS_EV_D, ipfsm_pkg::DS_EV_E, ipfsm_pkg::DS_EV_K: begin
				if (state_reg != ipfsm_pkg::ST_BLOCKED1) begin
					state_next = ipfsm_pkg::ST_BLOCKED1;
					fe_valid_next = (state_reg != ipfsm_pkg::ST_BLOCKED2);
					fe_code_next = ipfsm_pkg::FE_BLOCK;
				end
			end
			ipfsm_pkg::DS_EV_L: begin
				if ((state_reg == ipfsm_pkg::ST_BLOCKED1) || (state_reg == ipfsm_pkg::ST_OPER))
					state_next = ipfsm_pkg::ST_BLOCKED2;
				fe_valid_next = (state_reg == ipfsm_pkg::ST_OPER);
				fe_code_next = ipfsm_pkg::FE_BLOCK;
				rep_valid_next = (state_reg == ipfsm_pkg::ST_BLOCKED1) ||
					(state_reg == ipfsm_pkg::ST_BLOCKED2) ||
					(state_reg == ipfsm_pkg::ST_OPER);
			end
			default: begin
				state_next = ipfsm_pkg::ST_BLOCKED2;
				fe_valid_next = (state_reg != ipfsm_pkg::ST_BLOCKED1) &&
					(state_reg != ipfsm_pkg::ST_BLOCKED2);
				fe_code_next = ipfsm_pkg::FE_BLOCK;
			end
			endcase
		end else if (mgmt_go) begin
			case (mgmt_code_i)
			ipfsm_pkg::PRIM_UNBLK_REQ: begin
				case (state_reg)
				ipfsm_pkg::ST_BLOCKED1: begin
					prim_valid_next = 1'b1;
					prim_code_next = ipfsm_pkg::PRIM_BLOCK_IND;
				end
				ipfsm_pkg::ST_BLOCKED2: begin
					fe_valid_next = 1'b1;
					fe_code_next = ipfsm_pkg::FE_UNBLOCK;
					state_next = ipfsm_pkg::ST_LOCAL_UB;
				end
				ipfsm_pkg::ST_LOCAL_UB: begin
					fe_valid_next = 1'b1;
					fe_code_next = ipfsm_pkg::FE_UNBLOCK;
				end
				ipfsm_pkg::ST_REMOTE1: begin
					fe_valid_next = 1'b1;
					fe_code_next = ipfsm_pkg::FE_BLOCK;
					prim_valid_next = 1'b1;
					prim_code_next = ipfsm_pkg::PRIM_BLOCK_IND;
					state_next = ipfsm_pkg::ST_BLOCKED1;
				end
				ipfsm_pkg::ST_REMOTE2, ipfsm_pkg::ST_OPER: begin
					fe_valid_next = 1'b1;
					fe_code_next = ipfsm_pkg::FE_UNBLOCK;
					prim_valid_next = 1'b1;
					prim_code_next = ipfsm_pkg::PRIM_UNBLK_IND;
					state_next = ipfsm_pkg::ST_OPER;
				end
				default: begin
					prim_valid_next = 1'b1;
					prim_code_next = ipfsm_pkg::PRIM_PL_ACT_IND;
				end
				endcase
			end
			ipfsm_pkg::PRIM_BLOCK_IND: begin
				fe_valid_next = 1'b1;
				fe_code_next = ipfsm_pkg::FE_BLOCK;
				if (state_reg == ipfsm_pkg::ST_REMOTE1)
					state_next = ipfsm_pkg::ST_BLOCKED1;
				else if (state_reg != ipfsm_pkg::ST_BLOCKED1)
					state_next = ipfsm_pkg::ST_BLOCKED2;
			end
			ipfsm_pkg::PRIM_BLOCK_REQ: begin
				fe_valid_next = (state_reg == ipfsm_pkg::ST_OPER);
				fe_code_next = ipfsm_pkg::FE_BLOCK_REQ;
			end
			ipfsm_pkg::PRIM_USER_FAIL, ipfsm_pkg::PRIM_NET_FAIL: begin
				fe_valid_next = (state_reg == ipfsm_pkg::ST_BLOCKED1) ||
					(state_reg == ipfsm_pkg::ST_BLOCKED2) ||
					(state_reg == ipfsm_pkg::ST_REMOTE1) ||
					(state_reg == ipfsm_pkg::ST_REMOTE2);
				fe_code_next = (mgmt_code_i == ipfsm_pkg::PRIM_USER_FAIL) ?
					ipfsm_pkg::FE_TE_OOS : ipfsm_pkg::FE_NET_FAIL;
			end
			ipfsm_pkg::PRIM_PL_ACT_REQ: begin
				if (state_reg == ipfsm_pkg::ST_LOCAL_UB) begin
					state_next = ipfsm_pkg::ST_PERM_LINE;
					prim_valid_next = 1'b1;
					prim_code_next = ipfsm_pkg::PRIM_PL_ACT_IND;
				end
			end
			ipfsm_pkg::PRIM_PL_DEA_REQ: begin
				if (state_reg == ipfsm_pkg::ST_PERM_LINE) begin
					state_next = ipfsm_pkg::ST_BLOCKED2;
					prim_valid_next = 1'b1;
					prim_code_next = ipfsm_pkg::PRIM_PL_DEA_IND;
				end
			end
			ipfsm_pkg::PRIM_GRADING: begin
				fe_valid_next = (state_reg == ipfsm_pkg::ST_OPER);
				fe_code_next = ipfsm_pkg::FE_GRADING;
			end
			default: begin
			end
			endcase
		end else if (le_go) begin
			case (le_fe_code_i)
			ipfsm_pkg::FE_UNBLOCK: begin
				prim_valid_next = 1'b1;
				prim_code_next = ipfsm_pkg::PRIM_UNBLK_REQ;
				case (state_reg)
				ipfsm_pkg::ST_BLOCKED1: state_next = ipfsm_pkg::ST_REMOTE1;
				ipfsm_pkg::ST_BLOCKED2: state_next = ipfsm_pkg::ST_REMOTE2;
				ipfsm_pkg::ST_LOCAL_UB, ipfsm_pkg::ST_PERM_LINE: begin
					prim_code_next = ipfsm_pkg::PRIM_UNBLK_IND;
					state_next = ipfsm_pkg::ST_OPER;
				end
				ipfsm_pkg::ST_OPER: begin
					prim_code_next = ipfsm_pkg::PRIM_UNBLK_IND;
					fe_valid_next = 1'b1;
					fe_code_next = ipfsm_pkg::FE_UNBLOCK;
				end
				default: begin
				end
				endcase
			end
			ipfsm_pkg::FE_BLOCK: begin
				prim_valid_next = (state_reg != ipfsm_pkg::ST_BLOCKED1) &&
					(state_reg != ipfsm_pkg::ST_BLOCKED2);
				prim_code_next = ipfsm_pkg::PRIM_BLOCK_IND;
				if (state_reg == ipfsm_pkg::ST_REMOTE1)
					state_next = ipfsm_pkg::ST_BLOCKED1;
				else if ((state_reg == ipfsm_pkg::ST_LOCAL_UB) ||
					(state_reg == ipfsm_pkg::ST_REMOTE2) || (state_reg == ipfsm_pkg::ST_OPER))
					state_next = ipfsm_pkg::ST_BLOCKED2;
			end
			ipfsm_pkg::FE_DCH_BLOCK, ipfsm_pkg::FE_DCH_UNBLK: begin
				prim_valid_next = (state_reg == ipfsm_pkg::ST_OPER);
				prim_code_next = (le_fe_code_i == ipfsm_pkg::FE_DCH_BLOCK) ?
					ipfsm_pkg::PRIM_DCH_BLOCK : ipfsm_pkg::PRIM_DCH_UNBLK;
			end
			default: begin
			end
			endcase
		end
	end

	// D-channel blocking lives only while operational; leaving clears it.
	always_comb begin
		dch_next = dch_reg;
		if (le_go && (state_reg == ipfsm_pkg::ST_OPER)) begin
			if (le_fe_code_i == ipfsm_pkg::FE_DCH_BLOCK)
				dch_next = 1'b1;
			else if (le_fe_code_i == ipfsm_pkg::FE_DCH_UNBLK)
				dch_next = 1'b0;
		end
		if (state_next != ipfsm_pkg::ST_OPER)
			dch_next = 1'b0;
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg      <= ipfsm_pkg::STATE_RESET;
			fe_valid_reg   <= 1'b0;
			fe_code_reg    <= ipfsm_pkg::FE_NONE;
			prim_valid_reg <= 1'b0;
			prim_code_reg  <= ipfsm_pkg::PRIM_NONE;
			rep_valid_reg  <= 1'b0;
			rep_code_reg   <= ipfsm_pkg::DS_NORMAL;
			dch_reg        <= 1'b0;
		end else begin
			state_reg      <= state_next;
			fe_valid_reg   <= fe_valid_next;
			fe_code_reg    <= fe_code_next;
			prim_valid_reg <= prim_valid_next;
			prim_code_reg  <= prim_code_next;
			rep_valid_reg  <= rep_valid_next;
			rep_code_reg   <= rep_code_next;
			dch_reg        <= dch_next;
		end
	end

	assign le_fe_valid_o     = fe_valid_reg;
	assign le_fe_code_o      = fe_code_reg;
	assign mgmt_valid_o      = prim_valid_reg;
	assign mgmt_code_o       = prim_code_reg;
	assign ds_report_valid_o = rep_valid_reg;
	assign ds_report_code_o  = rep_code_reg;
	assign ds_condition_o    = ds_if.active_code;
	assign ds_multi_o        = ds_if.evt_multi;
	assign dch_blocked_o     = dch_reg;
	assign state_o           = state_reg;
	// Alarm toward the user in blocked 2, local unblock and remote unblock 2 only.
	assign user_rai_o        = !((state_reg == ipfsm_pkg::ST_BLOCKED1) ||
		(state_reg == ipfsm_pkg::ST_REMOTE1) || (state_reg == ipfsm_pkg::ST_OPER) ||
		(state_reg == ipfsm_pkg::ST_PERM_LINE));

	a_pl_activate: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		mgmt_go && (mgmt_code_i == ipfsm_pkg::PRIM_PL_ACT_REQ) &&
		(state_reg == ipfsm_pkg::ST_LOCAL_UB) |=>
		(state_reg == ipfsm_pkg::ST_PERM_LINE) && mgmt_valid_o &&
		(mgmt_code_o == ipfsm_pkg::PRIM_PL_ACT_IND))
		else $error("permanent-line activation not confirmed");

	a_pl_deactivate: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		mgmt_go && (mgmt_code_i == ipfsm_pkg::PRIM_PL_DEA_REQ) &&
		(state_reg == ipfsm_pkg::ST_PERM_LINE) |=>
		(state_reg == ipfsm_pkg::ST_BLOCKED2) && (mgmt_code_o == ipfsm_pkg::PRIM_PL_DEA_IND))
		else $error("permanent-line deactivation not indicated");

	a_dch_cleared: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		dch_blocked_o |-> (state_reg == ipfsm_pkg::ST_OPER))
		else $error("D-channel still blocked outside operational state");

	a_unblock_ind_oper: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		mgmt_valid_o && (mgmt_code_o == ipfsm_pkg::PRIM_UNBLK_IND) |->
		(state_reg == ipfsm_pkg::ST_OPER))
		else $error("unblock indication while not operational");

	a_oper_check_local: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		mgmt_go && (mgmt_code_i == ipfsm_pkg::PRIM_UNBLK_REQ) &&
		(state_reg == ipfsm_pkg::ST_OPER) |=> mgmt_valid_o)
		else $error("operational check not answered in one cycle");

	a_block_ind_sent: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		mgmt_go && (mgmt_code_i == ipfsm_pkg::PRIM_BLOCK_IND) &&
		(state_reg == ipfsm_pkg::ST_OPER) |=>
		le_fe_valid_o && (le_fe_code_o == ipfsm_pkg::FE_BLOCK) &&
		(state_reg == ipfsm_pkg::ST_BLOCKED2))
		else $error("block indication did not block the port");

	a_remote_blocked: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		le_go && (le_fe_code_i == ipfsm_pkg::FE_BLOCK) &&
		(state_reg == ipfsm_pkg::ST_REMOTE1) |=>
		(state_reg == ipfsm_pkg::ST_BLOCKED1) && (mgmt_code_o == ipfsm_pkg::PRIM_BLOCK_IND))
		else $error("remote unblock not undone by block element");

	a_fail_element: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		mgmt_go && (mgmt_code_i == ipfsm_pkg::PRIM_NET_FAIL) &&
		(state_reg == ipfsm_pkg::ST_BLOCKED1) |=>
		le_fe_valid_o && (le_fe_code_o == ipfsm_pkg::FE_NET_FAIL))
		else $error("network failure element not sent");

	a_alarm_state: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		$changed(state_reg) && (state_reg == ipfsm_pkg::ST_LOCAL_UB) |-> user_rai_o)
		else $error("no remote alarm in local unblock");
endmodule
